// File: src/ccs_pkg.sv
// Package of constants and types for the charge cycle sequencer
package ccs_pkg;
   // Register indices; the control path uses one word each
   localparam logic [3:0] CCS_ADDR_CTRL    = 4'h0;  // 0: hiz, 1: inhibit
   localparam logic [3:0] CCS_ADDR_ICC     = 4'h2;  // Fast charge current
   localparam logic [3:0] CCS_ADDR_TERMINATION_CURRENT_LEVEL   = 4'h3;  // Term/pre current
   localparam logic [3:0] CCS_ADDR_VREG    = 4'h4;  // Target voltage
   localparam logic [3:0] CCS_ADDR_TERM    = 4'h5;  // Term enable / hold
   localparam logic [3:0] CCS_ADDR_SYS     = 4'h7;  // System target
   localparam logic [3:0] CCS_ADDR_STATUS  = 4'h9;  // Phase and faults
   // Field positions
   localparam int CCS_CTRL_HIZ_BIT     = 0;
   localparam int CCS_CTRL_INH_BIT     = 1;
   localparam int CCS_TERM_EN_BIT      = 4;
   localparam int CCS_TERM_HOLD_BIT    = 0;
   localparam int CCS_VREG_LSB         = 2;
   // Reset values
   localparam logic [7:0] CCS_CTRL_RST  = 8'h00;
   localparam logic [7:0] CCS_ICC_RST   = 8'h0B;
   localparam logic [7:0] CCS_TERMINATION_CURRENT_LEVEL_RST = 8'h01;
   localparam logic [7:0] CCS_VREG_RST  = 8'hA0;
   localparam logic [7:0] CCS_TERM_RST  = 8'h10;
   localparam logic [7:0] CCS_SYS_RST   = 8'h00;
   // Timing, in the printed units, and cycle counts at 250 MHz
   localparam longint CCS_CLK_HZ       = 64'd250_000_000;
   localparam longint CCS_IMMUNITY_US  = 64'd200;
   localparam longint CCS_TERM_DGL_MS  = 64'd3200;
   localparam longint CCS_PRE_TMO_S    = 64'd3600;
   localparam longint CCS_IMMUNITY_CYC = CCS_CLK_HZ / 64'd1_000_000
                                         * CCS_IMMUNITY_US;
   localparam longint CCS_TERM_DGL_CYC = CCS_CLK_HZ / 64'd1000
                                         * CCS_TERM_DGL_MS;
   localparam longint CCS_PRE_TMO_CYC  = CCS_CLK_HZ * CCS_PRE_TMO_S;
   localparam int     CCS_TW           = 48;
   typedef enum logic [2:0] {
      CCS_IDLE, CCS_PRE, CCS_FAST, CCS_CV, CCS_TERM_WAIT, CCS_DONE,
      CCS_FAULT
   } ccs_phase_t;
   // Status codes shown to software
   localparam logic [1:0] CCS_STAT_OFF   = 2'h0;
   localparam logic [1:0] CCS_STAT_PRE   = 2'h1;
   localparam logic [1:0] CCS_STAT_CHG   = 2'h2;
   localparam logic [1:0] CCS_STAT_DONE  = 2'h3;
endpackage : ccs_pkg

// File: src/ccs_regs.sv
// Control register file with one-cycle read data
`timescale 1ns/1ps
module ccs_regs import ccs_pkg::*; (
   input  wire logic       ref_clk_i,
   input  wire logic       srst_i,
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   input  wire logic [7:0] status_i,
   output logic [7:0]      rdata_o,
   output logic [7:0]      ctrl_o,
   output logic [7:0]      icc_o,
   output logic [7:0]      termination_current_level_o,
   output logic [7:0]      vreg_o,
   output logic [7:0]      term_o,
   output logic [7:0]      sys_o
);
   typedef struct packed {
      logic [7:0] ctrl, icc, termination_current_level, vreg, term, sys, rdata;
   } ccs_reg_t;
   ccs_reg_t s_q;
   ccs_reg_t s_d;
   always_comb begin
      s_d = s_q;
      s_d.rdata = 8'h00;
      if (wr_i) begin
         case (addr_i)
            CCS_ADDR_CTRL:  s_d.ctrl  = {6'h00, wdata_i[1:0]};
            CCS_ADDR_ICC:   s_d.icc   = {2'h0, wdata_i[5:0]};
            CCS_ADDR_TERMINATION_CURRENT_LEVEL: s_d.termination_current_level = {4'h0, wdata_i[3:0]};
            CCS_ADDR_VREG:  s_d.vreg  = wdata_i;
            CCS_ADDR_TERM:  s_d.term  = wdata_i;
            CCS_ADDR_SYS:   s_d.sys   = {4'h0, wdata_i[3:0]};
            default: ;
         endcase
      end
      if (rd_i) begin
         case (addr_i)
            CCS_ADDR_CTRL:   s_d.rdata = s_q.ctrl;
            CCS_ADDR_ICC:    s_d.rdata = s_q.icc;
            CCS_ADDR_TERMINATION_CURRENT_LEVEL:  s_d.rdata = s_q.termination_current_level;
            CCS_ADDR_VREG:   s_d.rdata = s_q.vreg;
            CCS_ADDR_TERM:   s_d.rdata = s_q.term;
            CCS_ADDR_SYS:    s_d.rdata = s_q.sys;
            CCS_ADDR_STATUS: s_d.rdata = status_i;
            default:         s_d.rdata = 8'h00;
         endcase
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         s_q <= {CCS_CTRL_RST, CCS_ICC_RST, CCS_TERMINATION_CURRENT_LEVEL_RST, CCS_VREG_RST,
                 CCS_TERM_RST, CCS_SYS_RST, 8'h00};
      end else begin
         s_q <= s_d;
      end
   end
   assign rdata_o = s_q.rdata;
   assign ctrl_o  = s_q.ctrl;
   assign icc_o   = s_q.icc;
   assign termination_current_level_o = s_q.termination_current_level;
   assign vreg_o  = s_q.vreg;
   assign term_o  = s_q.term;
   assign sys_o   = s_q.sys;
endmodule : ccs_regs

// File: src/ccs_sequencer.sv
// Charge cycle sequencer top: source check, switches, charge phases
// Operation
// - Input pass switch opens at once when input leaves its normal range.
// - Good input must stay normal for 200 us before switch closes.
// - Only srst_i resets the registers; input undervoltage returns the phase to idle.
// - Hi-Z bit forces input switch off; inhibit forces battery off charging.
// - System target is a four-bit field at register 07h.
// - Pre-charge depleted battery to threshold with termination-current code.
// - Pre-charge not done by one-hour timer stops cycle with timeout fault.
// - Above threshold enter fast charge using six-bit current field.
// - At target voltage switch constant current to constant voltage.
// - Termination enabled: 3.2 s delay at termination current, then done.
// - Hold bit set keeps constant voltage and reports charging.
// - Termination disabled keeps constant voltage and reports charging.
// - New cycle on power recycle, enable or recharge, when fault free.
// - After done, recharge when battery below threshold and input good.
// - Recharge allowed only with termination on and hold off.
// - Battery overvoltage suspends charging at once and flags a fault.
// - Over-temperature reduces charge current.
// - Without input the battery switch is fully on.
// - Safety timer starts on fast charge, restarts on cycle or toggles.
// - Thermistor out of window pauses charging, resumes when back.
`timescale 1ns/1ps
module ccs_sequencer import ccs_pkg::*; #(
   parameter longint IMMUNITY_CYC = CCS_IMMUNITY_CYC,
   parameter longint TERM_DGL_CYC = CCS_TERM_DGL_CYC,
   parameter longint PRE_TMO_CYC  = CCS_PRE_TMO_CYC,
   parameter longint SAFE_TMO_CYC = CCS_PRE_TMO_CYC * 64'd5
) (
   input  wire logic       ref_clk_i,
   input  wire logic       srst_i,
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic [7:0]      rdata_o,
   input  wire logic       in_uvlo_ok_i,
   input  wire logic       in_ovp_i,
   input  wire logic       batt_above_pre_i,
   input  wire logic       batt_at_target_i,
   input  wire logic       batt_below_rech_i,
   input  wire logic       batt_ovp_i,
   input  wire logic       termination_current_level_reached_i,
   input  wire logic       ntc_ok_i,
   input  wire logic       die_hot_i,
   input  wire logic       charge_req_i,
   output logic            input_pass_switch_o,
   output logic            battery_switch_o,
   output logic            charging_o,
   output logic            cv_mode_o,
   output logic            current_reduce_o,
   output logic [5:0]      charge_current_code_o,
   output logic [5:0]      battery_target_voltage_o,
   output logic [3:0]      sys_target_o,
   output logic [1:0]      charge_status_o,
   output logic            timeout_fault_o,
   output logic            batt_ovp_fault_o,
   output logic            ntc_fault_o
);
   typedef struct packed {
      ccs_phase_t phase;
      logic       in_good;
      logic       in_good_p;
      logic       ipass;
      logic       bsw;
      logic       chg;
      logic       cv;
      logic       hot;
      logic [5:0] icode;
      logic [5:0] vcode;
      logic [3:0] scode;
      logic [1:0] stat;
      logic       tmo;
      logic       bovp;
      logic       ntcf;
      logic       hiz_p;
      logic       inh_p;
      logic       req_p;
   } ccs_state_t;

   ccs_state_t s_q;
   ccs_state_t s_d;

   logic [7:0] ctrl, icc, termination_current_level, vreg, term, sys, status;
   logic       in_norm, hiz, inh, term_en, term_hold;
   logic       imm_done, pre_done, dgl_done, safe_done;
   logic       new_cycle, cycle_ok, timer_clr;

   function automatic logic [CCS_TW-1:0] lim(input longint c);
      lim = (c < 64'd1) ? CCS_TW'(1) : c[CCS_TW-1:0];
   endfunction : lim

   assign status = {2'b00, s_q.ntcf, s_q.bovp, s_q.tmo, s_q.cv, s_q.stat};

   ccs_regs u_regs (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .addr_i    (addr_i),
      .wdata_i   (wdata_i),
      .wr_i      (wr_i),
      .rd_i      (rd_i),
      .status_i  (status),
      .rdata_o   (rdata_o),
      .ctrl_o    (ctrl),
      .icc_o     (icc),
      .termination_current_level_o   (termination_current_level),
      .vreg_o    (vreg),
      .term_o    (term),
      .sys_o     (sys)
   );

   assign hiz       = ctrl[CCS_CTRL_HIZ_BIT];
   assign inh       = ctrl[CCS_CTRL_INH_BIT];
   assign term_en   = term[CCS_TERM_EN_BIT];
   assign term_hold = term[CCS_TERM_HOLD_BIT];
   assign in_norm   = in_uvlo_ok_i && !in_ovp_i;

   // Timer clear: new cycle, hiz release edge, any inhibit edge
   assign timer_clr = new_cycle || (s_q.hiz_p && !hiz)
                      || (s_q.inh_p != inh);

   ccs_timer u_imm (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .clr_i     (1'b0),
      .run_i     (in_norm),
      .limit_i   (lim(IMMUNITY_CYC)),
      .done_o    (imm_done)
   );
   ccs_timer u_pre (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .clr_i     (timer_clr),
      .run_i     (s_q.phase == CCS_PRE),
      .limit_i   (lim(PRE_TMO_CYC)),
      .done_o    (pre_done)
   );
   ccs_timer u_dgl (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .clr_i     (timer_clr),
      .run_i     (s_q.phase == CCS_TERM_WAIT),
      .limit_i   (lim(TERM_DGL_CYC)),
      .done_o    (dgl_done)
   );
   ccs_timer u_safe (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .clr_i     (timer_clr),
      .run_i     (s_q.phase == CCS_FAST || s_q.phase == CCS_CV
                  || s_q.phase == CCS_TERM_WAIT),
      .limit_i   (lim(SAFE_TMO_CYC)),
      .done_o    (safe_done)
   );

   // Faults and inhibit that block a new cycle
   assign cycle_ok = ntc_ok_i && !s_q.tmo && !batt_ovp_i && !inh;
   assign new_cycle = cycle_ok && s_q.in_good && (
                        (s_q.in_good && !s_q.in_good_p)
                        || (charge_req_i && !s_q.req_p)
                        || (s_q.inh_p && !inh)
                        || (s_q.phase == CCS_DONE && batt_below_rech_i
                            && term_en && !term_hold));

   always_comb begin
      s_d = s_q;
      s_d.hiz_p     = hiz;
      s_d.inh_p     = inh;
      s_d.req_p     = charge_req_i;
      s_d.in_good_p = s_q.in_good;
      // Good source only after immunity window
      s_d.in_good = in_norm && (imm_done || s_q.in_good);
      s_d.ipass   = in_norm && s_d.in_good && !hiz;
      s_d.scode   = sys[3:0];
      s_d.vcode   = vreg[7:CCS_VREG_LSB];
      s_d.hot     = die_hot_i;
      s_d.bovp    = batt_ovp_i;
      s_d.ntcf    = !ntc_ok_i && s_q.phase != CCS_IDLE
                    && s_q.phase != CCS_DONE && s_q.phase != CCS_FAULT;
      if (!s_q.in_good) begin
         s_d.phase = CCS_IDLE;
      end else if (new_cycle) begin
         s_d.phase = batt_above_pre_i ? CCS_FAST : CCS_PRE;
         s_d.tmo   = 1'b0;
      end else begin
         case (s_q.phase)
            CCS_PRE: begin
               if (batt_above_pre_i) begin
                  s_d.phase = CCS_FAST;
               end else if (pre_done) begin
                  s_d.phase = CCS_FAULT;
                  s_d.tmo   = 1'b1;
               end
            end
            CCS_FAST: begin
               if (safe_done) begin
                  s_d.phase = CCS_FAULT;
                  s_d.tmo   = 1'b1;
               end else if (batt_at_target_i) begin
                  s_d.phase = CCS_CV;
               end
            end
            CCS_CV: begin
               if (safe_done) begin
                  s_d.phase = CCS_FAULT;
                  s_d.tmo   = 1'b1;
               end else if (termination_current_level_reached_i && term_en) begin
                  s_d.phase = CCS_TERM_WAIT;
               end
            end
            CCS_TERM_WAIT: begin
               if (!term_en) begin
                  s_d.phase = CCS_CV;
               end else if (dgl_done && !term_hold) begin
                  s_d.phase = CCS_DONE;
               end
            end
            CCS_DONE, CCS_IDLE, CCS_FAULT: ;
            default: s_d.phase = CCS_IDLE;
         endcase
      end
      // Charging is paused by faults but phase is kept
      s_d.chg = s_d.in_good && !inh && !batt_ovp_i && ntc_ok_i
                && (s_d.phase == CCS_PRE || s_d.phase == CCS_FAST
                    || s_d.phase == CCS_CV
                    || s_d.phase == CCS_TERM_WAIT);
      s_d.cv  = s_d.chg && (s_d.phase == CCS_CV
                            || s_d.phase == CCS_TERM_WAIT);
      s_d.icode = (s_d.phase == CCS_PRE) ? {2'b00, termination_current_level[3:0]}
                                         : icc[5:0];
      // Without input battery fully on; inhibit only matters outside idle and done
      s_d.bsw = !s_d.in_good ? 1'b1
                : (s_d.chg || !(inh && s_d.phase != CCS_IDLE
                   && s_d.phase != CCS_DONE));
      case (s_d.phase)
         CCS_PRE:  s_d.stat = CCS_STAT_PRE;
         CCS_FAST, CCS_CV, CCS_TERM_WAIT: s_d.stat = CCS_STAT_CHG;
         CCS_DONE: s_d.stat = CCS_STAT_DONE;
         default:  s_d.stat = CCS_STAT_OFF;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign input_pass_switch_o      = s_q.ipass;
   assign battery_switch_o         = s_q.bsw;
   assign charging_o               = s_q.chg;
   assign cv_mode_o                = s_q.cv;
   assign current_reduce_o         = s_q.hot;
   assign charge_current_code_o    = s_q.icode;
   assign battery_target_voltage_o = s_q.vcode;
   assign sys_target_o             = s_q.scode;
   assign charge_status_o          = s_q.stat;
   assign timeout_fault_o          = s_q.tmo;
   assign batt_ovp_fault_o         = s_q.bovp;
   assign ntc_fault_o              = s_q.ntcf;
endmodule : ccs_sequencer

// File: src/ccs_timer.sv
// Cycle timer with clear and run, flags expiry as a level
`timescale 1ns/1ps
module ccs_timer import ccs_pkg::*; #(
   parameter int W = CCS_TW
) (
   input  wire logic         ref_clk_i,
   input  wire logic         srst_i,
   input  wire logic         clr_i,
   input  wire logic         run_i,
   input  wire logic [W-1:0] limit_i,
   output logic              done_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         done;
   } ccs_tmr_t;
   ccs_tmr_t s_q;
   ccs_tmr_t s_d;
   always_comb begin
      s_d = s_q;
      if (clr_i || !run_i) begin
         s_d.cnt  = '0;
         s_d.done = 1'b0;
      end else if (s_q.cnt + W'(1) >= limit_i) begin
         s_d.done = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + W'(1);
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign done_o = s_q.done;
endmodule : ccs_timer

// File: test/ccs_host_model.sv
// Host model: register writes and reads over the strobe port
`timescale 1ns/1ps
module ccs_host_model (
   input  wire logic       ref_clk_i,
   output logic [3:0]      addr_o,
   output logic [7:0]      wdata_o,
   output logic            wr_o,
   output logic            rd_o,
   input  wire logic [7:0] rdata_i
);
   initial begin
      addr_o  = 4'h0;
      wdata_o = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end
   // Idle bus shows inverted values, never the last request
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge ref_clk_i);
      wr_o    <= 1'b0;
      addr_o  <= ~a;
      wdata_o <= ~d;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge ref_clk_i);
      rd_o   <= 1'b0;
      addr_o <= ~a;
      @(posedge ref_clk_i);
      d = rdata_i;
   endtask : rd
endmodule : ccs_host_model

// File: test/ccs_monitor.sv
// Checker of switch, status and fault timing at the sequencer ports
`timescale 1ns/1ps
module ccs_monitor import ccs_pkg::*; #(
   parameter longint IMMUNITY_CYC = CCS_IMMUNITY_CYC,
   parameter longint TERM_DGL_CYC = CCS_TERM_DGL_CYC
) (
   input wire logic       ref_clk_i,
   input wire logic       srst_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic       in_uvlo_ok_i,
   input wire logic       in_ovp_i,
   input wire logic       batt_ovp_i,
   input wire logic       termination_current_level_reached_i,
   input wire logic       ntc_ok_i,
   input wire logic       input_pass_switch_o,
   input wire logic       battery_switch_o,
   input wire logic       charging_o,
   input wire logic [1:0] charge_status_o,
   input wire logic       batt_ovp_fault_o
);
   logic [15:0] norm_q;
   logic [15:0] term_q;
   logic [1:0]  stat_q;
   logic        hiz_q;
   logic        inh_q;
   logic        ten_q;
   logic        hold_q;
   logic        done_rise;
   assign done_rise = charge_status_o == CCS_STAT_DONE &&
                      stat_q != CCS_STAT_DONE;
   // Saturating runs of good input and of termination current
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         norm_q <= 16'h0000;
         term_q <= 16'h0000;
         stat_q <= CCS_STAT_OFF;
         hiz_q  <= CCS_CTRL_RST[CCS_CTRL_HIZ_BIT];
         inh_q  <= CCS_CTRL_RST[CCS_CTRL_INH_BIT];
         ten_q  <= CCS_TERM_RST[CCS_TERM_EN_BIT];
         hold_q <= CCS_TERM_RST[CCS_TERM_HOLD_BIT];
      end else begin
         norm_q <= (in_uvlo_ok_i && !in_ovp_i) ?
                   norm_q + {15'h0000, ~&norm_q} : 16'h0000;
         term_q <= termination_current_level_reached_i ? term_q + {15'h0000, ~&term_q} :
                   16'h0000;
         stat_q <= charge_status_o;
         if (wr_i && addr_i == CCS_ADDR_CTRL) begin
            hiz_q <= wdata_i[CCS_CTRL_HIZ_BIT];
            inh_q <= wdata_i[CCS_CTRL_INH_BIT];
         end
         if (wr_i && addr_i == CCS_ADDR_TERM) begin
            ten_q  <= wdata_i[CCS_TERM_EN_BIT];
            hold_q <= wdata_i[CCS_TERM_HOLD_BIT];
         end
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   a_ovp_opens_sw: assert property (
      in_ovp_i || !in_uvlo_ok_i |-> ##[1:2] !input_pass_switch_o)
      else $error("input switch closed with input out of range");
   a_immunity_wait: assert property (
      $rose(input_pass_switch_o) |-> norm_q >= IMMUNITY_CYC)
      else $error("input switch closed before immunity time");
   a_hiz_forces_off: assert property (
      hiz_q && $past(hiz_q) |-> !input_pass_switch_o)
      else $error("input switch closed in high impedance mode");
   a_inhibit_stops: assert property (
      inh_q && $past(inh_q) |-> !charging_o)
      else $error("charging while inhibited");
   a_term_dwell: assert property (
      done_rise |-> term_q >= TERM_DGL_CYC)
      else $error("done reported before termination delay");
   a_done_allowed: assert property (
      done_rise |-> $past(ten_q) && !$past(hold_q))
      else $error("done reported with termination off or held");
   a_bovp_suspend: assert property (
      charging_o && batt_ovp_i |-> ##[1:2] (!charging_o && batt_ovp_fault_o))
      else $error("battery overvoltage did not stop charging");
   a_no_input_bat: assert property (
      !in_uvlo_ok_i [*3] |-> battery_switch_o)
      else $error("battery switch open without input");
   a_ntc_pause: assert property (
      !ntc_ok_i [*2] |-> !charging_o)
      else $error("charging with thermistor out of window");
endmodule : ccs_monitor

bind ccs_sequencer ccs_monitor #(
   .IMMUNITY_CYC(IMMUNITY_CYC), .TERM_DGL_CYC(TERM_DGL_CYC)
) u_mon (
   .ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .in_uvlo_ok_i(in_uvlo_ok_i),
   .in_ovp_i(in_ovp_i), .batt_ovp_i(batt_ovp_i),
   .termination_current_level_reached_i(termination_current_level_reached_i), .ntc_ok_i(ntc_ok_i),
   .input_pass_switch_o(input_pass_switch_o),
   .battery_switch_o(battery_switch_o), .charging_o(charging_o),
   .charge_status_o(charge_status_o), .batt_ovp_fault_o(batt_ovp_fault_o)
);

// File: test/tb.sv
// Bench: register table rows, then charge phases and faults
`timescale 1ns/1ps
module tb;
   import ccs_pkg::*;
   localparam longint IMM = 20;
   localparam longint DGL = 30;
   localparam longint PRE = 50;
   typedef struct packed {
      logic       w;
      logic [3:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } ccs_row_t;
   localparam ccs_row_t ROWS [15] = '{
      '{1'b0, CCS_ADDR_CTRL, 8'h00, CCS_CTRL_RST},
      '{1'b0, CCS_ADDR_ICC, 8'h00, CCS_ICC_RST},
      '{1'b0, CCS_ADDR_TERMINATION_CURRENT_LEVEL, 8'h00, CCS_TERMINATION_CURRENT_LEVEL_RST},
      '{1'b0, CCS_ADDR_VREG, 8'h00, CCS_VREG_RST},
      '{1'b0, CCS_ADDR_TERM, 8'h00, CCS_TERM_RST},
      '{1'b0, CCS_ADDR_SYS, 8'h00, CCS_SYS_RST},
      '{1'b0, CCS_ADDR_STATUS, 8'h00, 8'h00},
      '{1'b0, 4'h1, 8'h00, 8'h00},
      '{1'b1, 4'h1, 8'hFF, 8'h00},
      '{1'b1, CCS_ADDR_STATUS, 8'hFF, 8'h00},
      '{1'b1, CCS_ADDR_ICC, 8'hFF, 8'h3F},
      '{1'b1, CCS_ADDR_TERMINATION_CURRENT_LEVEL, 8'hFF, 8'h0F},
      '{1'b1, CCS_ADDR_VREG, 8'hFF, 8'hFF},
      '{1'b1, CCS_ADDR_TERM, 8'hFF, 8'hFF},
      '{1'b1, CCS_ADDR_SYS, 8'hFF, 8'h0F}};
   logic ref_clk_i = 1'b0, srst_i = 1'b1, in_ok = 1'b0, ovp = 1'b0;
   logic b_pre = 1'b0, b_tgt = 1'b0, rech = 1'b0, b_ovp = 1'b0;
   logic termination_current_level = 1'b0, ntc = 1'b1, hot = 1'b0, req = 1'b0;
   logic [3:0] addr, sys;
   logic [7:0] wdata, rdata, rv, flags;
   logic [5:0] icode, vcode;
   logic [1:0] stat;
   logic wr, rd;
   int errors = 0, n_compared = 0;
   initial forever #2 ref_clk_i = ~ref_clk_i;
   ccs_host_model u_host (.ref_clk_i(ref_clk_i), .addr_o(addr),
      .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
   ccs_sequencer #(.IMMUNITY_CYC(IMM), .TERM_DGL_CYC(DGL),
      .PRE_TMO_CYC(PRE), .SAFE_TMO_CYC(64'd200)) uut (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .in_uvlo_ok_i(in_ok), .in_ovp_i(ovp), .batt_above_pre_i(b_pre),
      .batt_at_target_i(b_tgt), .batt_below_rech_i(rech),
      .batt_ovp_i(b_ovp), .termination_current_level_reached_i(termination_current_level), .ntc_ok_i(ntc),
      .die_hot_i(hot), .charge_req_i(req),
      .input_pass_switch_o(flags[0]), .battery_switch_o(flags[1]),
      .charging_o(flags[2]), .current_reduce_o(flags[3]),
      .cv_mode_o(flags[4]), .timeout_fault_o(flags[5]),
      .batt_ovp_fault_o(flags[6]), .ntc_fault_o(flags[7]),
      .charge_current_code_o(icode), .battery_target_voltage_o(vcode),
      .sys_target_o(sys), .charge_status_o(stat));
   task automatic close_out;
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_flag(input int k, input logic v, input int lim);
      for (int i = 0; i < lim && flags[k] !== v; i++) @(posedge ref_clk_i);
      chk({7'h00, flags[k]}, {7'h00, v});
      if (flags[k] !== v) close_out();
   endtask : wait_flag
   task automatic wait_stat(input logic [1:0] v, input int lim);
      for (int i = 0; i < lim && stat !== v; i++) @(posedge ref_clk_i);
      chk({6'h00, stat}, {6'h00, v});
      if (stat !== v) close_out();
   endtask : wait_stat
   task automatic do_rst;
      srst_i <= 1'b1;
      in_ok  <= 1'b0;
      req    <= 1'b0;
      repeat (5) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      in_ok  <= 1'b1;
   endtask : do_rst
   task automatic start_chg;
      wait_flag(0, 1'b1, IMM + 10);
      req <= 1'b1;
      @(posedge ref_clk_i);
   endtask : start_chg
   initial begin
      repeat (5) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      foreach (ROWS[i]) begin
         if (ROWS[i].w) u_host.wr(ROWS[i].a, ROWS[i].d);
         u_host.rd(ROWS[i].a, rv);
         chk(rv, ROWS[i].e);
      end
      chk({4'h0, sys}, 8'h0F);
      chk({2'h0, vcode}, 8'h3F);
      do_rst;
      u_host.rd(CCS_ADDR_ICC, rv);
      chk(rv, CCS_ICC_RST);
      // Glitch in mid immunity restarts the wait
      repeat (IMM / 2) @(posedge ref_clk_i);
      in_ok <= 1'b0;
      @(posedge ref_clk_i);
      in_ok <= 1'b1;
      repeat (IMM - 2) @(posedge ref_clk_i);
      chk({7'h00, flags[0]}, 8'h00);
      wait_flag(0, 1'b1, 10);
      ovp <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      chk({7'h00, flags[0]}, 8'h00);
      ovp <= 1'b0;
      wait_flag(0, 1'b1, IMM + 10);
      u_host.wr(CCS_ADDR_CTRL, 8'h01);
      repeat (3) @(posedge ref_clk_i);
      chk({7'h00, flags[0]}, 8'h00);
      u_host.wr(CCS_ADDR_CTRL, 8'h00);
      start_chg;
      wait_stat(CCS_STAT_PRE, 10);
      chk({2'h0, icode}, {4'h0, CCS_TERMINATION_CURRENT_LEVEL_RST[3:0]});
      b_pre <= 1'b1;
      wait_stat(CCS_STAT_CHG, 10);
      chk({2'h0, icode}, {2'h0, CCS_ICC_RST[5:0]});
      hot <= 1'b1;
      wait_flag(3, 1'b1, 3);
      hot <= 1'b0;
      b_tgt <= 1'b1;
      wait_flag(4, 1'b1, 10);
      termination_current_level <= 1'b1;
      repeat (DGL - 5) @(posedge ref_clk_i);
      chk({6'h00, stat}, {6'h00, CCS_STAT_CHG});
      wait_stat(CCS_STAT_DONE, 20);
      {b_tgt, termination_current_level, rech} <= 3'b001;
      wait_stat(CCS_STAT_CHG, 20);
      rech <= 1'b0;
      b_ovp <= 1'b1;
      wait_flag(6, 1'b1, 3);
      b_ovp <= 1'b0;
      wait_flag(2, 1'b1, 10);
      ntc <= 1'b0;
      wait_flag(7, 1'b1, 3);
      ntc <= 1'b1;
      wait_flag(2, 1'b1, 10);
      u_host.wr(CCS_ADDR_CTRL, 8'h02);
      wait_flag(2, 1'b0, 3);
      in_ok <= 1'b0;
      wait_flag(1, 1'b1, 3);
      // Held and disabled termination keep charging in CV
      do_rst;
      u_host.wr(CCS_ADDR_TERM, 8'h11);
      {b_tgt, termination_current_level} <= 2'b11;
      start_chg;
      wait_flag(4, 1'b1, 20);
      repeat (DGL + 10) @(posedge ref_clk_i);
      chk({6'h00, stat}, {6'h00, CCS_STAT_CHG});
      u_host.wr(CCS_ADDR_TERM, 8'h00);
      repeat (DGL + 10) @(posedge ref_clk_i);
      chk({6'h00, stat}, {6'h00, CCS_STAT_CHG});
      do_rst;
      {b_pre, b_tgt, termination_current_level} <= 3'b000;
      start_chg;
      wait_flag(5, 1'b1, PRE + 20);
      chk({7'h00, flags[2]}, 8'h00);
      req <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      req <= 1'b1;
      repeat (5) @(posedge ref_clk_i);
      chk({7'h00, flags[2]}, 8'h00);
      // Safety timer runs out in fast charge
      do_rst;
      b_pre <= 1'b1;
      start_chg;
      wait_stat(CCS_STAT_CHG, 10);
      wait_flag(5, 1'b1, 250);
      chk({7'h00, flags[2]}, 8'h00);
      close_out();
   end
endmodule : tb
